// ==== core/dmpd_phase_detector.sv ====
// Top of the dual-modulus phase detector: dividers, phase/frequency detector,
// pump pair, lock indicator, monitors and buffered oscillator output.
// Assumes all inputs are synchronous to CLK; the prescaler rises once per count.
`timescale 1ns/1ps

module dmpd_phase_detector #(
	parameter int N_W = dmpd_pkg::N_WIDTH,
	parameter int A_W = dmpd_pkg::A_WIDTH,
	parameter int R_W = dmpd_pkg::R_WIDTH,
	parameter int MIN_PULSE = dmpd_pkg::MIN_PULSE_CYC
) (
	// Clock and reset.
	input wire logic CLK,
	input wire logic RST,
	// Reference oscillator and prescaler output.
	input wire logic OSC_IN,
	input wire logic VCO_IN,
	// Programmed divisors, from the loading path.
	input wire logic [N_W-1:0] N_VALUE,
	input wire logic [A_W-1:0] A_VALUE,
	input wire logic [R_W-1:0] R_VALUE,
	// Single-ended three-state error output.
	output logic SINGLE_ENDED_ERROR_OUT,
	output logic SINGLE_ENDED_ERROR_OE,
	// Double-ended pump pair, active low.
	output logic REF_PUMP_N,
	output logic VCO_PUMP_N,
	// Prescaler control and monitors.
	output logic MODULUS_SELECT_OUT,
	output logic REF_DIVIDED_OUT,
	output logic VCO_DIVIDED_OUT,
	output logic LOCK_INDICATOR,
	output logic BUFFERED_OSC_OUT
);

	// Refuse widths the logic cannot serve.
	if (N_W < 2 || A_W < 1 || R_W < 2 || MIN_PULSE < 1 || MIN_PULSE > 256)
		$error("dmpd_phase_detector: unsupported parameters");

	// Detector states, one-hot.
	typedef enum logic [3:0] {
		PD_IDLE = 4'h1,
		PD_VLEAD = 4'h2,
		PD_RLEAD = 4'h4,
		PD_BOTH = 4'h8
	} dmpd_pd_state_t;

	// Rising-edge detect of a sampled input.
	function automatic logic rise(input logic now, input logic prev);
		return now & ~prev;
	endfunction : rise

	// Clamp a requested value into a legal range.
	function automatic logic [N_W-1:0] clamp_n(input logic [N_W-1:0] v);
		return (v < N_W'(dmpd_pkg::N_MIN)) ? N_W'(dmpd_pkg::N_MIN) : v;
	endfunction : clamp_n

	// Previous input samples for edge detection.
	logic osc_prev_ff;
	logic vco_prev_ff;
	logic osc_edge;
	logic vco_edge;
	// Effective divisors after range limiting.
	logic [N_W-1:0] n_eff;
	logic [A_W-1:0] a_eff;
	logic [R_W-1:0] r_eff;
	// Reference divider.
	logic [R_W-1:0] r_count_ff;
	logic ref_div_ff;
	logic ref_tick;
	// Divided VCO from the counter pair.
	logic mod_sel;
	logic vco_tick;
	logic vco_div_ff;
	// Detector state and pulse counter.
	dmpd_pd_state_t pd_state_ff;
	dmpd_pd_state_t nxt_pd_state;
	logic [7:0] both_cnt_ff;
	// Registered outputs.
	dmpd_pkg::dmpd_pump_t pump_ff;
	dmpd_pkg::dmpd_tri_t err_ff;
	logic lock_ff;
	logic buf_osc_ff;
	logic mod_out_ff;

	////////////////////////////////////////////////////////////////////////////////
	// Edge detection on the synchronous inputs.
	always_ff @(posedge CLK)
	begin
		if (RST)
		begin
			osc_prev_ff <= 1'b0;
			vco_prev_ff <= 1'b0;
		end
		else
		begin
			osc_prev_ff <= OSC_IN;
			vco_prev_ff <= VCO_IN;
		end
	end

	assign osc_edge = rise(OSC_IN, osc_prev_ff);
	assign vco_edge = rise(VCO_IN, vco_prev_ff);

	// Out-of-range divisors are pulled to the nearest legal value.
	assign n_eff = clamp_n(N_VALUE);
	assign a_eff = A_VALUE;
	assign r_eff = (R_VALUE < R_W'(dmpd_pkg::R_MIN)) ? R_W'(dmpd_pkg::R_MIN) : R_VALUE;

	////////////////////////////////////////////////////////////////////////////////
	// Reference divider; the tick marks the divided reference rising edge.
	always_ff @(posedge CLK)
	begin
		if (RST)
		begin
			r_count_ff <= r_eff;
			ref_div_ff <= 1'b0;
		end
		else if (osc_edge)
		begin
			if (r_count_ff <= R_W'(1))
			begin
				r_count_ff <= r_eff;
				ref_div_ff <= 1'b1;
			end
			else
			begin
				r_count_ff <= r_count_ff - R_W'(1);
				// Drop the monitor at mid count for a visible duty cycle.
				if (r_count_ff <= ((r_eff >> 1) + R_W'(1)))
					ref_div_ff <= 1'b0;
			end
		end
	end

	assign ref_tick = osc_edge && (r_count_ff <= R_W'(1));

	////////////////////////////////////////////////////////////////////////////////
	// Dual-modulus counter pair.
	dmpd_modulus_ctrl #(
		.N_W(N_W),
		.A_W(A_W)
	) u_modulus (
		.clk(CLK),
		.rst(RST),
		.n_value(n_eff),
		.a_value(a_eff),
		.vco_edge(vco_edge),
		.mod_select(mod_sel),
		.cycle_end(vco_tick)
	);

	// Divided VCO monitor: high from each N end, low once the modulus select is high after the A portion.
	always_ff @(posedge CLK)
	begin
		if (RST)
			vco_div_ff <= 1'b0;
		else if (vco_tick)
			vco_div_ff <= 1'b1;
		else if (mod_sel)
			vco_div_ff <= 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Phase/frequency detector on the divided rising edges.
	always_comb
	begin
		nxt_pd_state = pd_state_ff;
		unique case (pd_state_ff)
			PD_IDLE:
			begin
				if (ref_tick && vco_tick)
					nxt_pd_state = PD_BOTH;
				else if (vco_tick)
					nxt_pd_state = PD_VLEAD;
				else if (ref_tick)
					nxt_pd_state = PD_RLEAD;
			end
			PD_VLEAD:
			begin
				// The lagging reference edge closes the pulse.
				if (ref_tick)
					nxt_pd_state = PD_BOTH;
			end
			PD_RLEAD:
			begin
				if (vco_tick)
					nxt_pd_state = PD_BOTH;
			end
			PD_BOTH:
			begin
				// Joint low pulse lasts the minimum width, then resets.
				if (both_cnt_ff >= 8'(MIN_PULSE - 1))
					nxt_pd_state = PD_IDLE;
			end
		endcase
	end

	// Detector state register and joint-pulse width counter.
	always_ff @(posedge CLK)
	begin
		if (RST)
		begin
			pd_state_ff <= PD_IDLE;
			both_cnt_ff <= 8'h00;
		end
		else
		begin
			pd_state_ff <= nxt_pd_state;
			if (nxt_pd_state == PD_BOTH && pd_state_ff == PD_BOTH)
				both_cnt_ff <= both_cnt_ff + 8'h01;
			else
				both_cnt_ff <= 8'h00;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Pump pair: VCO pump low when leading, reference pump low when lagging.
	always_ff @(posedge CLK)
	begin
		if (RST)
			pump_ff <= '{ref_pump_n: 1'b1, vco_pump_n: 1'b1};
		else
		begin
			pump_ff.vco_pump_n <= !(nxt_pd_state == PD_VLEAD || nxt_pd_state == PD_BOTH);
			pump_ff.ref_pump_n <= !(nxt_pd_state == PD_RLEAD || nxt_pd_state == PD_BOTH);
		end
	end

	// Single-ended output: low on lead, high on lag, floating otherwise.
	always_ff @(posedge CLK)
	begin
		if (RST)
			err_ff <= '{level: 1'b0, oe: 1'b0};
		else
		begin
			unique case (nxt_pd_state)
				PD_VLEAD: err_ff <= '{level: 1'b0, oe: 1'b1};
				PD_RLEAD: err_ff <= '{level: 1'b1, oe: 1'b1};
				PD_IDLE, PD_BOTH: err_ff <= '{level: 1'b0, oe: 1'b0};
			endcase
		end
	end

	// Lock indicator pulses low while either single pump pulse is active.
	always_ff @(posedge CLK)
	begin
		if (RST)
			lock_ff <= 1'b1;
		else
			lock_ff <= (nxt_pd_state == PD_IDLE || nxt_pd_state == PD_BOTH);
	end

	////////////////////////////////////////////////////////////////////////////////
	// Buffered oscillator and registered modulus select.
	always_ff @(posedge CLK)
	begin
		if (RST)
		begin
			buf_osc_ff <= 1'b0;
			mod_out_ff <= (a_eff == '0);
		end
		else
		begin
			buf_osc_ff <= OSC_IN;
			mod_out_ff <= mod_sel;
		end
	end

	// Outputs straight from flip-flops.
	assign SINGLE_ENDED_ERROR_OUT = err_ff.level;
	assign SINGLE_ENDED_ERROR_OE = err_ff.oe;
	assign REF_PUMP_N = pump_ff.ref_pump_n;
	assign VCO_PUMP_N = pump_ff.vco_pump_n;
	assign MODULUS_SELECT_OUT = mod_out_ff;
	assign REF_DIVIDED_OUT = ref_div_ff;
	assign VCO_DIVIDED_OUT = vco_div_ff;
	assign LOCK_INDICATOR = lock_ff;
	assign BUFFERED_OSC_OUT = buf_osc_ff;

endmodule : dmpd_phase_detector

// ==== pkg/dmpd_pkg.sv ====
// Shared constants and carrier types for the dual-modulus phase detector.
// Assumes a single 125 MHz clock; all pin inputs are synchronous to it.
package dmpd_pkg;

	// Clock period in ns.
	localparam int CLK_PERIOD_NS = 8;
	// Minimum width of the in-lock pump pulse, in ns.
	localparam int MIN_PULSE_NS = 16;
	// Least time rounds up, never below one cycle.
	localparam int MIN_PULSE_CYC = ((MIN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS) < 1 ? 1 :
		((MIN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

	// Counter widths and legal ranges.
	localparam int N_WIDTH = 10;
	localparam int A_WIDTH = 7;
	localparam int R_WIDTH = 14;
	localparam logic [N_WIDTH-1:0] N_MIN = 10'h003;
	localparam logic [N_WIDTH-1:0] N_MAX = 10'h3ff;
	localparam logic [A_WIDTH-1:0] A_MAX = 7'h7f;
	localparam logic [R_WIDTH-1:0] R_MIN = 14'h0003;

	// Reset values of the programmed divisors.
	localparam logic [N_WIDTH-1:0] N_RESET = 10'h003;
	localparam logic [A_WIDTH-1:0] A_RESET = 7'h00;

	// Double-ended pump pair, both active low.
	typedef struct packed {
		logic ref_pump_n;
		logic vco_pump_n;
	} dmpd_pump_t;

	// Single-ended three-state error output as data and enable.
	typedef struct packed {
		logic level;
		logic oe;
	} dmpd_tri_t;

endpackage : dmpd_pkg

// ==== core/dmpd_modulus_ctrl.sv ====
// Dual-modulus counter pair: the A and N down counters and the modulus select.
// Assumes vco_edge is a one-cycle pulse per rising edge of the prescaler output.
`timescale 1ns/1ps

module dmpd_modulus_ctrl #(
	parameter int N_W = dmpd_pkg::N_WIDTH,
	parameter int A_W = dmpd_pkg::A_WIDTH
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic rst,
	// Programmed divisors.
	input wire logic [N_W-1:0] n_value,
	input wire logic [A_W-1:0] a_value,
	// Edge of the prescaler output.
	input wire logic vco_edge,
	// Results.
	output logic mod_select,
	output logic cycle_end
);

	// Elaboration check on widths.
	if (N_W < 2 || A_W < 1 || A_W > N_W)
		$error("dmpd_modulus_ctrl: unsupported counter widths");

	// Down counters; A at zero has expired, N ends on the edge taken at one.
	logic [N_W-1:0] n_count_ff;
	logic [A_W-1:0] a_count_ff;
	// Modulus select, low during the A portion.
	logic mod_select_ff;
	// One-cycle pulse at the end of each N count.
	logic cycle_end_ff;

	////////////////////////////////////////////////////////////////////////////////
	// Counting. Both counters step together until A reaches zero; the N end reloads both.
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			n_count_ff <= n_value;
			a_count_ff <= a_value;
			cycle_end_ff <= 1'b0;
		end
		else
		begin
			cycle_end_ff <= 1'b0;
			if (vco_edge)
			begin
				if (n_count_ff <= N_W'(1))
				begin
					// End of N count: reload and repeat.
					n_count_ff <= n_value;
					a_count_ff <= a_value;
					cycle_end_ff <= 1'b1;
				end
				else
				begin
					// Each edge decrements both while they count.
					n_count_ff <= n_count_ff - N_W'(1);
					if (a_count_ff != '0)
						a_count_ff <= a_count_ff - A_W'(1);
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Modulus select: low while A counts, high for the N minus A rest.
	always_ff @(posedge clk)
	begin
		if (rst)
			mod_select_ff <= (a_value == '0);
		else if (vco_edge && n_count_ff <= N_W'(1))
			mod_select_ff <= (a_value == '0);
		else if (vco_edge && a_count_ff == A_W'(1))
			mod_select_ff <= 1'b1;
	end

	assign mod_select = mod_select_ff;
	assign cycle_end = cycle_end_ff;

endmodule : dmpd_modulus_ctrl

// ==== testbench/dmpd_phase_detector_assertions.sv ====
// Checker of the phase detector pins, bound to the top module.
// Assumes one clock domain and the synchronous active-high reset.
`timescale 1ns/1ps

module dmpd_phase_detector_assertions #(
	parameter int MIN_PULSE = dmpd_pkg::MIN_PULSE_CYC
) (
	// Clock and reset.
	input wire logic CLK,
	input wire logic RST,
	// Watched pins.
	input wire logic OSC_IN,
	input wire logic VCO_IN,
	input wire logic SINGLE_ENDED_ERROR_OUT,
	input wire logic SINGLE_ENDED_ERROR_OE,
	input wire logic REF_PUMP_N,
	input wire logic VCO_PUMP_N,
	input wire logic MODULUS_SELECT_OUT,
	input wire logic REF_DIVIDED_OUT,
	input wire logic LOCK_INDICATOR,
	input wire logic BUFFERED_OSC_OUT
);
	default clocking @(posedge CLK);
	endclocking
	default disable iff (RST);

	////////////////////////////////////////////////////////////////////////
	// Both pumps low together is the joint in-lock pulse.
	logic joint;
	assign joint = !REF_PUMP_N && !VCO_PUMP_N;
	// Length of the running joint pulse, so its width is checked exactly.
	int jcnt_ff;
	always_ff @(posedge CLK)
	begin
		jcnt_ff <= (RST || !joint) ? 0 : jcnt_ff + 1;
	end

	////////////////////////////////////////////////////////////////////////
	AST_ERR_LOW: assert property (
		SINGLE_ENDED_ERROR_OE && !SINGLE_ENDED_ERROR_OUT |-> !VCO_PUMP_N && REF_PUMP_N)
		else $error("Low error pulse without the VCO pump");
	AST_ERR_HIGH: assert property (
		SINGLE_ENDED_ERROR_OE && SINGLE_ENDED_ERROR_OUT |-> !REF_PUMP_N && VCO_PUMP_N)
		else $error("High error pulse without the reference pump");
	AST_ONE_SIDED: assert property (
		(REF_PUMP_N != VCO_PUMP_N) |-> SINGLE_ENDED_ERROR_OE)
		else $error("One-sided pump while error output floats");
	AST_FLOAT: assert property (
		!SINGLE_ENDED_ERROR_OE |-> REF_PUMP_N == VCO_PUMP_N)
		else $error("Pumps disagree while error output floats");
	AST_JOINT_WIDTH: assert property (
		$fell(joint) |-> jcnt_ff == MIN_PULSE)
		else $error("Joint pump pulse has the wrong width");
	AST_LOCK: assert property (
		LOCK_INDICATOR == (REF_PUMP_N == VCO_PUMP_N))
		else $error("Lock indicator does not follow the pumps");
	AST_BUF_OSC: assert property (
		!$past(RST) |-> BUFFERED_OSC_OUT == $past(OSC_IN))
		else $error("Buffered oscillator is not the input one cycle late");
	AST_REF_SPACING: assert property (
		$rose(REF_DIVIDED_OUT) |=> (!$rose(REF_DIVIDED_OUT))[*5])
		else $error("Divided reference ticks too close");
	AST_MOD_CAUSE: assert property (
		$changed(MODULUS_SELECT_OUT) |-> $past(VCO_IN) || $past(VCO_IN, 2) || $past(VCO_IN, 3))
		else $error("Modulus select moved without a prescaler edge");

	// Main scenarios reached.
	cover property ($rose(joint));
	cover property (SINGLE_ENDED_ERROR_OE && !SINGLE_ENDED_ERROR_OUT);
	cover property (SINGLE_ENDED_ERROR_OE && SINGLE_ENDED_ERROR_OUT);
endmodule : dmpd_phase_detector_assertions

// ==== testbench/dmpd_prescaler_model.sv ====
// Behavioural dual-modulus prescaler fed by a VCO running at the clock rate.
// Assumes the detector updates the modulus select well inside one period.
`timescale 1ns/1ps

module dmpd_prescaler_model #(
	parameter int P = 8
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic rst,
	// Modulus select, high selects divide by P.
	input wire logic mod_sel,
	// Divided VCO, high for one cycle per period.
	output logic pre_out
);
	// Position within the period; the select is looked at only when it ends.
	int cnt_ff;
	always_ff @(posedge clk)
	begin
		if (rst || cnt_ff >= (mod_sel ? P - 1 : P))
		begin
			cnt_ff <= 0;
		end
		else
		begin
			cnt_ff <= cnt_ff + 1;
		end
	end
	assign pre_out = !rst && cnt_ff == 0;
endmodule : dmpd_prescaler_model

// ==== testbench/test_dmpd_phase_detector.sv ====
// Self-checking bench of the dual-modulus phase detector.
// Assumes the prescaler model drives the VCO input; the bench drives the rest.
`timescale 1ns/1ps

module test_dmpd_phase_detector;
	localparam int PRE_P = 8;
	// Stimulus.
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic osc_in = 1'b0;
	logic [dmpd_pkg::N_WIDTH-1:0] n_val = dmpd_pkg::N_RESET;
	logic [dmpd_pkg::A_WIDTH-1:0] a_val = dmpd_pkg::A_RESET;
	logic [dmpd_pkg::R_WIDTH-1:0] r_val = dmpd_pkg::R_MIN;
	// Observed pins.
	logic vco_in, se_out, se_oe, ref_pump_n, vco_pump_n, mod_sel, fr, fv, lock, buf_osc;
	int err_total = 0;
	int checks_done = 0;
	int cyc = 0;

	dmpd_phase_detector u_dmpd_phase_detector (.CLK(clk), .RST(rst), .OSC_IN(osc_in), .VCO_IN(vco_in),
		.N_VALUE(n_val), .A_VALUE(a_val), .R_VALUE(r_val), .SINGLE_ENDED_ERROR_OUT(se_out),
		.SINGLE_ENDED_ERROR_OE(se_oe), .REF_PUMP_N(ref_pump_n), .VCO_PUMP_N(vco_pump_n),
		.MODULUS_SELECT_OUT(mod_sel), .REF_DIVIDED_OUT(fr), .VCO_DIVIDED_OUT(fv),
		.LOCK_INDICATOR(lock), .BUFFERED_OSC_OUT(buf_osc));
	dmpd_prescaler_model #(.P(PRE_P)) u_dmpd_prescaler_model (.clk(clk), .rst(rst), .mod_sel(mod_sel),
		.pre_out(vco_in));

	////////////////////////////////////////////////////////////////////////
	initial
	begin
		forever #4 clk = ~clk;
	end
	// Reference runs at half the clock, the fastest the input allows.
	always @(posedge clk) osc_in <= ~osc_in;
	// Hang guard, well above the longest expected run.
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 80000)
		begin
			err_total++;
			end_sim();
		end
	end

	task automatic end_sim();
		if (err_total == 0 && checks_done > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : end_sim

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			err_total++;
			$display("Error %0t: saw %0d expected %0d", $time, seen, exp);
		end
	endtask : check

	// Divisors are taken while reset is held.
	task automatic load_divisors(input int n, input int a, input int r);
		n_val <= n[dmpd_pkg::N_WIDTH-1:0];
		a_val <= a[dmpd_pkg::A_WIDTH-1:0];
		r_val <= r[dmpd_pkg::R_WIDTH-1:0];
		rst <= 1'b1;
		repeat (12) @(posedge clk);
		rst <= 1'b0;
	endtask : load_divisors

	// Times one whole divided period of each side and sorts prescaler edges by modulus.
	task automatic measure(input int n, input int a, input int r);
		int sv; int sr; int lv; int lr; int lo; int hi; int pv; int pr; int pi;
		{sv, sr, lv, lr, lo, hi, pv, pr, pi} = '0;
		load_divisors(n, a, r);
		for (int c = 0; c < 30000 && (sv < 3 || sr < 3); c++)
		begin
			@(posedge clk);
			#1;
			if (sv == 2)
			begin
				lv++;
				lo += (vco_in && !pi && mod_sel === 1'b0);
				hi += (vco_in && !pi && mod_sel === 1'b1);
			end
			lr += (sr == 2);
			sv += (fv === 1'b1 && !pv);
			sr += (fr === 1'b1 && !pr);
			pv = fv;
			pr = fr;
			pi = vco_in;
		end
		n = n < 3 ? 3 : n;
		r = r < 3 ? 3 : r;
		check(lv, PRE_P * n + a);
		check(lo, a);
		check(hi, n - a);
		check(lr, 2 * r);
	endtask : measure

	// A clearly faster or slower VCO must give error pulses of one polarity only.
	task automatic polarity(input int n, input int r, input logic fast);
		int lo; int hi; int ol;
		{lo, hi, ol} = '0;
		load_divisors(n, 0, r);
		repeat (4000)
		begin
			@(posedge clk);
			#1;
			lo += (se_oe === 1'b1 && se_out === 1'b0);
			hi += (se_oe === 1'b1 && se_out === 1'b1);
			ol += (lock === 1'b0);
		end
		check(lo > 0, fast);
		check(hi > 0, !fast);
		check(ol > 0, 1'b1);
	endtask : polarity

	////////////////////////////////////////////////////////////////////////
	initial
	begin
		int n;
		void'($urandom(10));
		measure(3, 0, 12);
		measure(2, 1, 2);
		measure(3, 2, 3);
		measure(1023, 127, 7);
		for (int i = 0; i < 5; i++)
		begin
			n = 3 + $urandom % 60;
			measure(n, $urandom % n, 3 + $urandom % 400);
		end
		polarity(3, 200, 1'b1);
		polarity(200, 3, 1'b0);
		end_sim();
	end
endmodule : test_dmpd_phase_detector

bind dmpd_phase_detector dmpd_phase_detector_assertions #(.MIN_PULSE(MIN_PULSE)) u_dmpd_phase_detector_assertions (
	.CLK(CLK), .RST(RST), .OSC_IN(OSC_IN), .VCO_IN(VCO_IN), .SINGLE_ENDED_ERROR_OUT(SINGLE_ENDED_ERROR_OUT),
	.SINGLE_ENDED_ERROR_OE(SINGLE_ENDED_ERROR_OE), .REF_PUMP_N(REF_PUMP_N), .VCO_PUMP_N(VCO_PUMP_N),
	.MODULUS_SELECT_OUT(MODULUS_SELECT_OUT), .REF_DIVIDED_OUT(REF_DIVIDED_OUT),
	.LOCK_INDICATOR(LOCK_INDICATOR), .BUFFERED_OSC_OUT(BUFFERED_OSC_OUT));
